// *** sleep_pkg.sv ***
// constants shared by the sleep-entry target logic
package sleep_pkg;
  localparam logic [7:0] SLEEP_ID_BYTE = 8'h86;
  localparam logic [7:0] RESERVED_ID_BYTE = 8'hf8;
  localparam logic [3:0] ACK_EDGE = 4'h9;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam int CLOCK_MHZ = 250;
  localparam int REC_TIME_US = 400;
  localparam int REC_CYCLES = REC_TIME_US * CLOCK_MHZ;
endpackage

// *** line_sync.sv ***
// two-flop synchroniser with scl edge detection and bus-condition detection for scl and sda
module line_sync (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl,
  output logic sda,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_seen,
  output logic stop_seen
);
  logic [1:0] scl_meta;
  logic [1:0] sda_meta;
  logic scl_d;
  logic sda_d;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      scl_meta <= 2'h3;
      sda_meta <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_meta <= {scl_meta[0], scl_in};
      sda_meta <= {sda_meta[0], sda_in};
      scl_d <= scl_meta[1];
      sda_d <= sda_meta[1];
    end
  end

  assign scl = scl_meta[1];
  assign sda = sda_meta[1];
  assign scl_rise = scl & ~scl_d;
  assign scl_fall = ~scl & scl_d;
  assign start_seen = scl & scl_d & sda_d & ~sda;
  assign stop_seen = scl & scl_d & ~sda_d & sda;
endmodule

// *** sleep_target.sv ***
// i2c target front end that recognises the sleep sequence and enters sleep
module sleep_target #(
  parameter logic [6:0] OWN_ADDR = 7'h50,
  parameter int REC_COUNT = sleep_pkg::REC_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic wake,
  output logic sda_out,
  output logic sda_oe,
  output logic sleeping,
  output logic recovering,
  output logic stop_by_target
);
  typedef enum {IDLE, SHIFT, ACK, SKIP} phase_t;
  typedef enum {SEQ_NONE, SEQ_RSV, SEQ_ADDR} seq_t;

  phase_t phase;
  seq_t seq;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [7:0] shreg;
  logic [3:0] bit_count;
  logic first_byte;
  logic release_pending;
  logic [31:0] rec_left;

  line_sync u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl(scl),
    .sda(sda),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen)
  );

  wire [7:0] next_byte = {shreg[6:0], sda};
  wire byte_done = scl_rise && (bit_count == sleep_pkg::DATA_BITS - 4'h1);
  wire is_rsv = first_byte && (next_byte == sleep_pkg::RESERVED_ID_BYTE);
  wire is_own = (seq == SEQ_RSV) && (next_byte[7:1] == OWN_ADDR) && !next_byte[0];
  // sleep byte only honoured after the full ordered sequence
  wire is_sleep = (seq == SEQ_ADDR) && first_byte
                  && (next_byte == sleep_pkg::SLEEP_ID_BYTE);
  wire do_ack = is_rsv || is_own || is_sleep;
  // ninth rising edge: the ack bit is being sampled
  wire ack_edge = (phase == ACK) && scl_rise;
  wire enter_sleep = ack_edge && release_pending;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      phase <= IDLE;
      seq <= SEQ_NONE;
      shreg <= 8'h00;
      bit_count <= 4'h0;
      first_byte <= 1'b0;
      release_pending <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      sleeping <= 1'b0;
      recovering <= 1'b0;
      rec_left <= 32'h0;
      stop_by_target <= 1'b0;
    end else begin
      stop_by_target <= 1'b0;
      if (sleeping) begin
        // deaf to the bus while asleep; a wake request starts recovery
        sda_oe <= 1'b0;
        if (wake) begin
          sleeping <= 1'b0;
          recovering <= 1'b1;
          rec_left <= 32'(REC_COUNT);
        end
      end else if (recovering) begin
        if (rec_left <= 32'h1) begin
          recovering <= 1'b0;
        end
        rec_left <= rec_left - 32'h1;
      end else if (start_seen) begin
        phase <= SHIFT;
        bit_count <= 4'h0;
        first_byte <= 1'b1;
        sda_oe <= 1'b0;
      end else if (stop_seen) begin
        phase <= IDLE;
        seq <= SEQ_NONE;
        sda_oe <= 1'b0;
      end else begin
        case (phase)
          SHIFT: begin
            if (scl_rise) begin
              shreg <= next_byte;
              bit_count <= bit_count + 4'h1;
            end
            if (byte_done) begin
              phase <= do_ack ? ACK : SKIP;
              release_pending <= is_sleep;
              first_byte <= 1'b0;
              if (is_rsv) begin
                seq <= SEQ_RSV;
              end else if (is_own) begin
                seq <= SEQ_ADDR;
              end else begin
                seq <= SEQ_NONE;
              end
            end
          end
          ACK: begin
            if (scl_fall && !sda_oe) begin
              sda_out <= 1'b0;
              sda_oe <= 1'b1;
            end
            if (enter_sleep) begin
              // no stop awaited; sda let go at the ninth rising edge
              sda_oe <= 1'b0;
              sleeping <= 1'b1;
              phase <= IDLE;
              seq <= SEQ_NONE;
              // scl is high here, so an undriven sda rises into a stop
              stop_by_target <= sda_oe & ~sda_out;
            end else if (scl_fall && sda_oe) begin
              sda_oe <= 1'b0;
              phase <= SKIP;
              bit_count <= 4'h0;
            end
          end
          SKIP: begin
            // rest of an ordinary transfer is not ours to decode
            sda_oe <= 1'b0;
          end
          default: begin
            phase <= IDLE;
          end
        endcase
      end
    end
  end

  sleep_on_ninth_a: assert property (@(posedge clock) disable iff (sys_rst)
    enter_sleep && !sleeping |=> sleeping && !sda_oe)
    else $error("sleep not entered at ninth scl edge");
  release_sda_a: assert property (@(posedge clock) disable iff (sys_rst)
    sleeping |-> !sda_oe)
    else $error("sda driven while asleep");
  ack_sleep_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(sleeping) |-> $past(sda_oe) && !$past(sda_out))
    else $error("sleep entered without acknowledge");
  no_stop_wait_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(sleeping) |-> $past(scl_rise))
    else $error("sleep entry not tied to scl edge");
  spurious_stop_a: assert property (@(posedge clock) disable iff (sys_rst)
    stop_by_target |-> sleeping && $past(scl))
    else $error("target stop flagged outside sleep entry");
  ordered_seq_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(sleeping) |-> $past(release_pending))
    else $error("sleep without full sequence");
  ack_drive_a: assert property (@(posedge clock) disable iff (sys_rst)
    sda_oe |-> !sda_out)
    else $error("target drove sda high");
  rec_done_a: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(recovering) |-> !sleeping)
    else $error("recovery ended while asleep");

  // reset must leave the bus released and the target awake
  rst_quiet_a: assert property (@(posedge clock)
    sys_rst |=> !sda_oe && !sleeping && !recovering && !stop_by_target)
    else $error("outputs active after reset");

  stop_pulse_a: assert property (@(posedge clock) disable iff (sys_rst)
    stop_by_target |=> !stop_by_target)
    else $error("target stop flag longer than one cycle");

  sleep_stop_a: assert property (@(posedge clock) disable iff (sys_rst)
    enter_sleep && sda_oe |=> stop_by_target)
    else $error("release with scl high not flagged");

  wake_exit_a: assert property (@(posedge clock) disable iff (sys_rst)
    sleeping && wake |=> !sleeping && recovering)
    else $error("wake did not start recovery");

  stay_asleep_a: assert property (@(posedge clock) disable iff (sys_rst)
    sleeping && !wake |=> sleeping)
    else $error("sleep left without wake");

  sleep_idle_a: assert property (@(posedge clock) disable iff (sys_rst)
    sleeping |-> phase == IDLE)
    else $error("bus decoding active while asleep");

  rec_release_a: assert property (@(posedge clock) disable iff (sys_rst)
    recovering |-> !sda_oe)
    else $error("sda driven during recovery");

  rec_load_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(recovering) |-> rec_left == 32'(REC_COUNT))
    else $error("recovery count not loaded");

  ack_on_fall_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(sda_oe) |-> $past(scl_fall) && phase == ACK)
    else $error("ack driven outside the ack slot");

  // a refused byte must never be answered
  skip_quiet_a: assert property (@(posedge clock) disable iff (sys_rst)
    phase == SKIP |=> !sda_oe)
    else $error("sda driven on a refused transfer");

  stop_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
    stop_seen && !sleeping && !recovering |=> seq == SEQ_NONE)
    else $error("stop did not clear the sequence");
endmodule

// *** i2c_ctl.sv ***
// controller model: scl generator and open-drain pull on sda
module i2c_ctl (
  output logic scl,
  output logic pull,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // scl stands high between frames, sda left to the pull-up
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic start();
    #40 pull = 1'b0;
    #40 scl = 1'b1;
    #80 pull = 1'b1;
    #40 scl = 1'b0;
  endtask
  task automatic stop();
    #40 pull = 1'b1;
    #40 scl = 1'b1;
    #80 pull = 1'b0;
    #80;
  endtask
  // no stop detection here, so a target-made stop is simply ignored
  task automatic put(input logic [7:0] b, input logic keep, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #40 pull = ~b[i];
      #40 scl = 1'b1;
      #80 scl = 1'b0;
    end
    #40 pull = 1'b0;
    #40 scl = 1'b1;
    ack = ~sda;
    pull = keep;
    #80 scl = 1'b0;
    #40 pull = 1'b0;
  endtask
endmodule

// *** tb.sv ***
// testbench for the sleep-entry target
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic wake = 1'b0;
  logic scl, pull, sda, a;
  logic sda_out, sda_oe, sleeping, recovering, stop_by_target;
  logic [7:0] b;
  int failures = 0;
  int checks_done = 0;
  int spur = 0;
  int tgt = 0;
  int rec = 0;
  always #2 clock = ~clock;
  assign sda = (pull | (sda_oe & ~sda_out)) ? 1'b0 : 1'b1;
  i2c_ctl u_ctl (.scl(scl), .pull(pull), .sda(sda));
  sleep_target #(.REC_COUNT(600)) u_dut (.clock(clock), .sys_rst(sys_rst),
    .scl_in(scl), .sda_in(sda), .wake(wake), .sda_out(sda_out), .sda_oe(sda_oe),
    .sleeping(sleeping), .recovering(recovering), .stop_by_target(stop_by_target));
  always @(posedge sda) if (scl) spur++;
  always @(posedge clock) begin
    tgt <= tgt + stop_by_target;
    rec <= rec + recovering;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: got %0h want %0h", $time, seen, want);
    end
  endtask
  task automatic end_of_test();
    if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic seq(input logic keep);
    @(negedge clock) spur = 0;
    tgt = 0;
    u_ctl.start(); u_ctl.put(8'hf8, 1'b0, a); check(a, 1);
    u_ctl.start(); u_ctl.put(8'ha0, 1'b0, a); check(a, 1);
    u_ctl.start(); u_ctl.put(8'h86, keep, a); check(a, 1);
    repeat (20) @(negedge clock);
    check(sleeping, 1);
    check(sda_oe, 0);
    check(sda_out, 0);
    check(tgt, 1);
    check(spur, !keep);
    rec = 0;
    @(posedge clock) wake <= 1'b1;
    @(posedge clock) wake <= 1'b0;
    // access inside the recovery span must go unanswered
    u_ctl.start(); u_ctl.put(8'ha0, 1'b0, a); check(a, 0);
    check(sleeping, 0);
    repeat (300) @(negedge clock);
    check(rec, 600);
    u_ctl.stop();
  endtask
  initial begin
    void'($urandom(32'h28938584));
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
    for (int i = 0; i < 3; i++) begin
      b = 8'($urandom);
      if (b == 8'hf8 || b[7:1] == 7'h50) b = 8'h86;
      u_ctl.start(); u_ctl.put(8'hf8, 1'b0, a); check(a, 1);
      u_ctl.start(); u_ctl.put(b, 1'b0, a); check(a, 0);
      u_ctl.start(); u_ctl.put(8'h86, 1'b0, a); check(a, 0);
      u_ctl.stop();
      check(sleeping, 0);
    end
    seq(1'b0);
    seq(1'b1);
    end_of_test();
  end
  initial begin
    #100us;
    failures++;
    end_of_test();
  end
endmodule
